// file: hw/soc_output_stage.v
`timescale 1ns/1ps
`default_nettype none
`include "soc_defs.vh"
// ==========================================================
// Summary of operation
// - three 15-bit results, each routable DAC or PWM
// - DAC only on main pin, PWM either pin
// - DAC fed with 11-bit code of result
// - continuous PWM, period from resolution and divider
// - resolution up to 12 bits
// - SPI command traffic suspends pulse output on first pin
// - two alarms with threshold, hysteresis, direction, delays
// - alarm window mode between two thresholds
// - SPI: second pin select in, first pin data out
// - listen for one-wire request 20 ms after reset
// - request in window keeps command mode until set
// - window expiry selects I2C or SPI per config
// - stored setting enables or skips start window
// - error forces output max or min, error code
// - watchdog supervises processor and measurement loop
// - bridge inputs outside limits flag broken wire
// - common-mode deviation flags sensor aging
// - memory and register check failures raise error
// - signature or parity failure raises error
// - no second alarm output while SPI configured
// - alarms evaluate bridge result only
module soc_output_stage #(
    parameter START_CYC = `SOC_START_CYC,
    parameter WDOG_CYC  = `SOC_WDOG_CYC,
    parameter DIV_W     = 8,
    parameter DW        = 16
) (
    input  wire                  ref_clk,
    input  wire                  rst,
    input  wire [`SOC_RES_W-1:0] bridge_result,
    input  wire [`SOC_RES_W-1:0] temp1_result,
    input  wire [`SOC_RES_W-1:0] temp2_result,
    input  wire [1:0]            dac_sel,
    input  wire [1:0]            pulse_one_sel,
    input  wire [1:0]            pulse_two_sel,
    input  wire                  dac_en,
    input  wire                  pulse_one_en,
    input  wire                  pulse_two_en,
    input  wire [3:0]            pwm_res,
    input  wire [DIV_W-1:0]      pwm_div,
    input  wire                  alarm_one_en,
    input  wire                  alarm_two_en,
    input  wire [`SOC_RES_W-1:0] a1_thr_lo,
    input  wire [`SOC_RES_W-1:0] a1_thr_hi,
    input  wire [`SOC_RES_W-1:0] a1_hyst,
    input  wire                  a1_dir_high,
    input  wire                  a1_window,
    input  wire [DW-1:0]         a1_on_dly,
    input  wire [DW-1:0]         a1_off_dly,
    input  wire [`SOC_RES_W-1:0] a2_thr_lo,
    input  wire [`SOC_RES_W-1:0] a2_thr_hi,
    input  wire [`SOC_RES_W-1:0] a2_hyst,
    input  wire                  a2_dir_high,
    input  wire                  a2_window,
    input  wire [DW-1:0]         a2_on_dly,
    input  wire [DW-1:0]         a2_off_dly,
    input  wire                  cfg_spi,
    input  wire                  cfg_start_win_en,
    input  wire                  onewire_req,
    input  wire                  cmd_exit,
    input  wire                  spi_sdo,
    input  wire                  spi_active,
    input  wire                  second_io_pin_in,
    input  wire                  proc_alive,
    input  wire                  loop_tick,
    input  wire                  inp_lo_fault,
    input  wire                  inp_hi_fault,
    input  wire                  cm_fault,
    input  wire                  mem_fault,
    input  wire                  sig_fault,
    input  wire                  parity_fault,
    input  wire                  err_clear,
    input  wire                  err_high_sel,
    output reg  [`SOC_DAC_W-1:0] dac_code_ff,
    output reg                   output_driver_a_ff,
    output reg                   output_driver_b_ff,
    output reg                   first_io_pin_oe_ff,
    output reg                   second_io_pin_out_ff,
    output reg                   second_io_pin_oe_ff,
    output reg                   spi_select_ff,
    output reg  [1:0]            if_mode_ff,
    output reg                   diag_mode_ff,
    output reg  [7:0]            err_code_ff
);
    // ======================================================
    // pin synchronisers
    reg [1:0] req_sync_ff;
    reg [1:0] ss_sync_ff;
    always @(posedge ref_clk) begin
        if (rst) begin
            req_sync_ff <= 2'h0;
            ss_sync_ff  <= 2'h3;
        end else begin
            req_sync_ff <= {req_sync_ff[0], onewire_req};
            ss_sync_ff  <= {ss_sync_ff[0], second_io_pin_in};
        end
    end
    wire req_s = req_sync_ff[1];
    // ======================================================
    // result routing
    function [`SOC_RES_W-1:0] pick;
        input [1:0] sel;
        begin
            case (sel)
                `SOC_SEL_BRIDGE: pick = bridge_result;
                `SOC_SEL_TEMP1:  pick = temp1_result;
                default:         pick = temp2_result;
            endcase
        end
    endfunction
    wire [`SOC_RES_W-1:0] dac_val = pick(dac_sel);
    wire [`SOC_RES_W-1:0] p1_val  = pick(pulse_one_sel);
    wire [`SOC_RES_W-1:0] p2_val  = pick(pulse_two_sel);
    // ======================================================
    // pwm divider and counter
    reg [DIV_W-1:0]         div_ff;
    reg [`SOC_MAX_RES-1:0]  pcnt_ff;
    wire pwm_tick = (div_ff == pwm_div);
    wire [3:0] res = (pwm_res > `SOC_MAX_RES) ? 4'hC :
                     (pwm_res < `SOC_MIN_RES) ? 4'h9 : pwm_res;
    wire [`SOC_MAX_RES-1:0] pmask =
        (12'hFFF >> (4'hC - res));
    always @(posedge ref_clk) begin
        if (rst) begin
            div_ff  <= {DIV_W{1'b0}};
            pcnt_ff <= 12'h000;
        end else begin
            div_ff <= pwm_tick ? {DIV_W{1'b0}} : div_ff + 1'b1;
            if (pwm_tick)
                pcnt_ff <= (pcnt_ff + 12'h001) & pmask;
        end
    end
    // upper bits of result, scaled to resolution
    wire [`SOC_MAX_RES-1:0] p1_cmp =
        p1_val[`SOC_RES_W-1 -: `SOC_MAX_RES] >> (4'hC - res);
    wire [`SOC_MAX_RES-1:0] p2_cmp =
        p2_val[`SOC_RES_W-1 -: `SOC_MAX_RES] >> (4'hC - res);
    wire p1_lvl = pcnt_ff < p1_cmp;
    wire p2_lvl = pcnt_ff < p2_cmp;
    // ======================================================
    // alarms on the bridge result only
    wire al1;
    wire al2;
    soc_alarm #(.W(`SOC_RES_W), .DW(DW)) u_alarm_one (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .value    (bridge_result),
        .thr_lo   (a1_thr_lo),
        .thr_hi   (a1_thr_hi),
        .hyst     (a1_hyst),
        .dir_high (a1_dir_high),
        .window_en(a1_window),
        .on_dly   (a1_on_dly),
        .off_dly  (a1_off_dly),
        .alarm_ff (al1)
    );
    soc_alarm #(.W(`SOC_RES_W), .DW(DW)) u_alarm_two (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .value    (bridge_result),
        .thr_lo   (a2_thr_lo),
        .thr_hi   (a2_thr_hi),
        .hyst     (a2_hyst),
        .dir_high (a2_dir_high),
        .window_en(a2_window),
        .on_dly   (a2_on_dly),
        .off_dly  (a2_off_dly),
        .alarm_ff (al2)
    );
    // ======================================================
    // interface start-up
    reg [31:0] win_ff;
    reg [1:0]  nxt_mode;
    wire [1:0] run_mode = cfg_spi ? `SOC_MODE_SPI : `SOC_MODE_I2C;
    always @* begin
        nxt_mode = if_mode_ff;
        case (if_mode_ff)
            `SOC_MODE_START: begin
                if (!cfg_start_win_en)
                    nxt_mode = run_mode;
                else if (req_s)
                    nxt_mode = `SOC_MODE_CMD;
                else if (win_ff >= START_CYC - 1)
                    nxt_mode = run_mode;
            end
            `SOC_MODE_CMD: begin
                if (cmd_exit)
                    nxt_mode = run_mode;
            end
            default: nxt_mode = if_mode_ff;
        endcase
    end
    always @(posedge ref_clk) begin
        if (rst) begin
            if_mode_ff <= `SOC_MODE_START;
            win_ff     <= 32'h0;
        end else begin
            if_mode_ff <= nxt_mode;
            if (if_mode_ff == `SOC_MODE_START)
                win_ff <= win_ff + 32'h1;
        end
    end
    // ======================================================
    // error detection
    reg [31:0] wd_ff;
    wire wd_kick = proc_alive & loop_tick;
    always @(posedge ref_clk) begin
        if (rst)
            wd_ff <= 32'h0;
        else if (wd_kick)
            wd_ff <= 32'h0;
        else if (wd_ff < WDOG_CYC)
            wd_ff <= wd_ff + 32'h1;
    end
    wire wd_err = (wd_ff >= WDOG_CYC);
    reg [7:0] code;
    always @* begin
        code = `SOC_ERR_NONE;
        if (sig_fault | parity_fault)
            code = `SOC_ERR_SIG;
        else if (mem_fault)
            code = `SOC_ERR_MEM;
        else if (inp_lo_fault | inp_hi_fault)
            code = `SOC_ERR_WIRE;
        else if (cm_fault)
            code = `SOC_ERR_AGING;
        else if (wd_err)
            code = `SOC_ERR_WDOG;
    end
    always @(posedge ref_clk) begin
        if (rst) begin
            diag_mode_ff <= 1'b0;
            err_code_ff  <= `SOC_ERR_NONE;
        end else if (code != `SOC_ERR_NONE) begin
            diag_mode_ff <= 1'b1;
            err_code_ff  <= code;
        end else if (err_clear) begin
            diag_mode_ff <= 1'b0;
            err_code_ff  <= `SOC_ERR_NONE;
        end
    end
    // ======================================================
    // output drivers
    wire spi_mode  = (if_mode_ff == `SOC_MODE_SPI);
    wire spi_cmd   = spi_mode & spi_active;
    always @(posedge ref_clk) begin
        if (rst) begin
            dac_code_ff          <= {`SOC_DAC_W{1'b0}};
            output_driver_a_ff   <= 1'b0;
            output_driver_b_ff   <= 1'b0;
            first_io_pin_oe_ff   <= 1'b0;
            second_io_pin_out_ff <= 1'b0;
            second_io_pin_oe_ff  <= 1'b0;
            spi_select_ff        <= 1'b1;
        end else begin
            spi_select_ff <= spi_mode ? ss_sync_ff[1] : 1'b1;
            if (diag_mode_ff)
                dac_code_ff <= {`SOC_DAC_W{err_high_sel}};
            else if (dac_en)
                dac_code_ff <= dac_val[`SOC_RES_W-1 -: `SOC_DAC_W];
            // main pin: dac path or second pulse channel
            if (diag_mode_ff)
                output_driver_a_ff <= err_high_sel;
            else
                output_driver_a_ff <= pulse_two_en & !dac_en & p2_lvl;
            // first pin: spi data, pulse one or alarm one
            if (spi_cmd) begin
                output_driver_b_ff <= spi_sdo;
                first_io_pin_oe_ff <= 1'b1;
            end else if (diag_mode_ff && pulse_one_en) begin
                output_driver_b_ff <= err_high_sel;
                first_io_pin_oe_ff <= 1'b1;
            end else if (pulse_one_en) begin
                output_driver_b_ff <= p1_lvl;
                first_io_pin_oe_ff <= 1'b1;
            end else if (alarm_one_en) begin
                output_driver_b_ff <= al1;
                first_io_pin_oe_ff <= 1'b1;
            end else begin
                output_driver_b_ff <= 1'b0;
                first_io_pin_oe_ff <= 1'b0;
            end
            second_io_pin_out_ff <= al2;
            second_io_pin_oe_ff  <= alarm_two_en & !cfg_spi;
        end
    end
endmodule // soc_output_stage
`default_nettype wire

// file: inc/soc_defs.vh
`ifndef SOC_DEFS_VH
`define SOC_DEFS_VH
// ==========================================================
// widths
`define SOC_RES_W        15
`define SOC_DAC_W        11
`define SOC_MAX_RES      12
`define SOC_MIN_RES      9
// ==========================================================
// result register selection codes
`define SOC_SEL_BRIDGE   2'h0
`define SOC_SEL_TEMP1    2'h1
`define SOC_SEL_TEMP2    2'h2
// ==========================================================
// interface modes
`define SOC_MODE_START   2'h0
`define SOC_MODE_CMD     2'h1
`define SOC_MODE_I2C     2'h2
`define SOC_MODE_SPI     2'h3
// ==========================================================
// timing
`define SOC_CLK_HZ       25000000
`define SOC_START_MS     20
`define SOC_START_CYC    (`SOC_CLK_HZ / 1000 * `SOC_START_MS)
`define SOC_WDOG_CYC     65536
// ==========================================================
// error codes for the serial output registers
`define SOC_ERR_NONE     8'h00
`define SOC_ERR_WDOG     8'h01
`define SOC_ERR_WIRE     8'h02
`define SOC_ERR_AGING    8'h03
`define SOC_ERR_MEM      8'h04
`define SOC_ERR_SIG      8'h05
`endif

// file: hw/soc_alarm.v
`timescale 1ns/1ps
`default_nettype none
`include "soc_defs.vh"
// ==========================================================
// one alarm comparator channel
module soc_alarm #(
    parameter W  = `SOC_RES_W,
    parameter DW = 16
) (
    input  wire          ref_clk,
    input  wire          rst,
    input  wire [W-1:0]  value,
    input  wire [W-1:0]  thr_lo,
    input  wire [W-1:0]  thr_hi,
    input  wire [W-1:0]  hyst,
    input  wire          dir_high,
    input  wire          window_en,
    input  wire [DW-1:0] on_dly,
    input  wire [DW-1:0] off_dly,
    output reg           alarm_ff
);
    reg          raw_ff;
    reg [DW-1:0] cnt_ff;
    reg          nxt_raw;
    reg [W:0]    lo_m;
    reg [W:0]    hi_p;
    always @* begin
        lo_m = {1'b0, thr_lo} - {1'b0, hyst};
        hi_p = {1'b0, thr_hi} + {1'b0, hyst};
        nxt_raw = raw_ff;
        if (window_en) begin
            if (raw_ff)
                nxt_raw = ({1'b0, value} > lo_m[W:0] || lo_m[W]) &&
                          ({1'b0, value} < hi_p);
            else
                nxt_raw = (value > thr_lo) && (value < thr_hi);
            if (!dir_high)
                nxt_raw = nxt_raw;
        end else if (raw_ff) begin
            nxt_raw = lo_m[W] || ({1'b0, value} > lo_m);
        end else begin
            nxt_raw = value > thr_lo;
        end
    end
    always @(posedge ref_clk) begin
        if (rst) begin
            raw_ff   <= 1'b0;
            cnt_ff   <= {DW{1'b0}};
            alarm_ff <= 1'b0;
        end else begin
            raw_ff <= nxt_raw;
            // on and off delay filter
            if ((raw_ff ^ ~dir_high) == alarm_ff) begin
                cnt_ff <= {DW{1'b0}};
            end else if (cnt_ff >= (alarm_ff ? off_dly : on_dly)) begin
                cnt_ff   <= {DW{1'b0}};
                alarm_ff <= ~alarm_ff;
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end
endmodule // soc_alarm
`default_nettype wire

// file: verification/soc_os_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "soc_defs.vh"
// ==========
// output stage checks
module soc_os_properties (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        inp_lo_fault,
    input wire logic        inp_hi_fault,
    input wire logic        cm_fault,
    input wire logic        mem_fault,
    input wire logic        sig_fault,
    input wire logic        parity_fault,
    input wire logic        err_clear,
    input wire logic        err_high_sel,
    input wire logic        cmd_exit,
    input wire logic [1:0]  if_mode_ff,
    input wire logic        diag_mode_ff,
    input wire logic [7:0]  err_code_ff,
    input wire logic [10:0] dac_code_ff,
    input wire logic        output_driver_a_ff,
    input wire logic        second_io_pin_oe_ff
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire any_fault = inp_lo_fault | inp_hi_fault | cm_fault | mem_fault
                   | sig_fault | parity_fault;
    // ==========
    // diagnostic walk
    sequence diag_walk_s;
        diag_mode_ff ##1 (dac_code_ff == {11{$past(err_high_sel)}});
    endsequence
    mode_sticky_a: assert property (if_mode_ff[1] |=> $stable(if_mode_ff))
        else $error("run mode changed");
    cmd_hold_a: assert property ((if_mode_ff == `SOC_MODE_CMD) && !cmd_exit
        |=> if_mode_ff == `SOC_MODE_CMD) else $error("command mode left");
    fault_walk_a: assert property (any_fault |=> diag_walk_s)
        else $error("fault did not force output");
    sig_code_a: assert property ((sig_fault || parity_fault)
        |=> err_code_ff == 8'h05) else $error("signature code wrong");
    mem_code_a: assert property ((mem_fault && !sig_fault && !parity_fault)
        |=> err_code_ff == 8'h04) else $error("memory code wrong");
    diag_hold_a: assert property (diag_mode_ff && !err_clear
        |=> diag_mode_ff) else $error("diagnostic mode dropped");
    diag_pin_a: assert property (diag_mode_ff
        |=> output_driver_a_ff == $past(err_high_sel))
        else $error("main pin not forced");
    spi_pin_two_a: assert property ((if_mode_ff == `SOC_MODE_SPI)
        |=> !second_io_pin_oe_ff) else $error("second pin driven in spi");
endmodule // soc_os_properties
`default_nettype wire

// file: verification/soc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// serial host on the far side
module soc_host_model (
    input  wire logic ref_clk,
    output logic      onewire_req,
    output logic      cmd_exit,
    output logic      spi_sdo,
    output logic      spi_active,
    output logic      second_io_pin_in
);
    initial begin
        {onewire_req, cmd_exit, spi_sdo, spi_active} = 4'h0;
        second_io_pin_in = 1'b1;
    end
    // data line idle pattern changes every cycle
    always @(negedge ref_clk) spi_sdo <= ~spi_sdo;
    // request held three cycles, used inside and after the start window
    task automatic send_req();
        @(negedge ref_clk) onewire_req = 1'b1;
        repeat (3) @(negedge ref_clk);
        onewire_req = 1'b0;
    endtask
    // spi frame: select low and serial core active while on
    task automatic spi_sel(input logic on);
        @(negedge ref_clk) {spi_active, second_io_pin_in} = {on, !on};
    endtask
    task automatic leave_cmd();
        @(negedge ref_clk) cmd_exit = 1'b1;
        @(negedge ref_clk) cmd_exit = 1'b0;
    endtask
endmodule // soc_host_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// output stage bench
module tb_top;
    logic        ref_clk, rst, dac_en, pulse_one_en, pulse_two_en,
                 alarm_one_en, alarm_two_en, a1_dir_high, a1_window,
                 a2_dir_high, a2_window, cfg_spi, cfg_start_win_en,
                 onewire_req, cmd_exit, spi_sdo, spi_active,
                 second_io_pin_in, proc_alive, loop_tick, inp_lo_fault,
                 inp_hi_fault, cm_fault, mem_fault, sig_fault,
                 parity_fault, err_clear, err_high_sel;
    logic [14:0] bridge_result, temp1_result, temp2_result, a1_thr_lo,
                 a1_thr_hi, a1_hyst, a2_thr_lo, a2_thr_hi, a2_hyst;
    logic [15:0] a1_on_dly, a1_off_dly, a2_on_dly, a2_off_dly;
    logic [1:0]  dac_sel, pulse_one_sel, pulse_two_sel, if_mode_ff;
    logic [3:0]  pwm_res;
    logic [7:0]  pwm_div, err_code_ff;
    logic [10:0] dac_code_ff;
    logic        output_driver_a_ff, output_driver_b_ff,
                 first_io_pin_oe_ff, second_io_pin_out_ff,
                 second_io_pin_oe_ff, spi_select_ff, diag_mode_ff;
    logic [7:0]  code_tbl [6] = '{8'h02, 8'h02, 8'h03, 8'h04, 8'h05, 8'h05};
    logic [14:0] res_tbl [3];
    int          num_errors = 0;
    int          checks = 0;
    soc_output_stage #(.START_CYC(50), .WDOG_CYC(20)) i_soc_output_stage (
        .ref_clk, .rst, .bridge_result, .temp1_result, .temp2_result,
        .dac_sel, .pulse_one_sel, .pulse_two_sel, .dac_en, .pulse_one_en,
        .pulse_two_en, .pwm_res, .pwm_div, .alarm_one_en, .alarm_two_en,
        .a1_thr_lo, .a1_thr_hi, .a1_hyst, .a1_dir_high, .a1_window,
        .a1_on_dly, .a1_off_dly, .a2_thr_lo, .a2_thr_hi, .a2_hyst,
        .a2_dir_high, .a2_window, .a2_on_dly, .a2_off_dly, .cfg_spi,
        .cfg_start_win_en, .onewire_req, .cmd_exit, .spi_sdo, .spi_active,
        .second_io_pin_in, .proc_alive, .loop_tick, .inp_lo_fault,
        .inp_hi_fault, .cm_fault, .mem_fault, .sig_fault, .parity_fault,
        .err_clear, .err_high_sel, .dac_code_ff, .output_driver_a_ff,
        .output_driver_b_ff, .first_io_pin_oe_ff, .second_io_pin_out_ff,
        .second_io_pin_oe_ff, .spi_select_ff, .if_mode_ff, .diag_mode_ff,
        .err_code_ff);
    soc_host_model i_soc_host_model (.ref_clk, .onewire_req, .cmd_exit,
        .spi_sdo, .spi_active, .second_io_pin_in);
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(input string what, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic do_reset(input logic spi, win);
        {cfg_spi, cfg_start_win_en, rst} = {spi, win, 1'b1};
        tick(2);
        rst = 1'b0;
    endtask
    // ==========
    // scenarios
    task automatic t_window();
        do_reset(1'b0, 1'b1);
        chk("reset select", spi_select_ff, 1'b1);
        chk("reset diag", diag_mode_ff, 1'b0);
        tick(40);
        chk("mode in window", if_mode_ff, 2'h0);
        tick(20);
        chk("mode after window", if_mode_ff, 2'h2);
        i_soc_host_model.send_req();
        tick(5);
        chk("late request", if_mode_ff, 2'h2);
    endtask
    task automatic t_cmd();
        do_reset(1'b1, 1'b1);
        tick(5);
        i_soc_host_model.send_req();
        tick(60);
        chk("command mode", if_mode_ff, 2'h1);
        i_soc_host_model.leave_cmd();
        tick(2);
        chk("command left", if_mode_ff == 2'h1, 1'b0);
        chk("spi run mode", if_mode_ff, 2'h3);
        pulse_one_en = 1'b1;
        i_soc_host_model.spi_sel(1'b1);
        tick(4);
        chk("select in", spi_select_ff, 1'b0);
        chk("sdo oe", first_io_pin_oe_ff, 1'b1);
        for (int i = 0; i < 2; i++) begin
            chk("sdo data", output_driver_b_ff, spi_sdo);
            tick(1);
        end
        i_soc_host_model.spi_sel(1'b0);
        tick(4);
        chk("select idle", spi_select_ff, 1'b1);
        chk("pulse resumed", output_driver_b_ff, 1'b0);
        pulse_one_en = 1'b0;
    endtask
    task automatic t_nowin();
        do_reset(1'b1, 1'b0);
        alarm_two_en = 1'b1;
        tick(2);
        chk("skip window", if_mode_ff, 2'h3);
        chk("second pin oe", second_io_pin_oe_ff, 1'b0);
    endtask
    task automatic t_route();
        do_reset(1'b0, 1'b0);
        res_tbl = '{15'h5A5A, 15'h1234, 15'h7FFF};
        {bridge_result, temp1_result, temp2_result} =
            {res_tbl[0], res_tbl[1], res_tbl[2]};
        dac_en = 1'b1;
        for (int i = 0; i < 3; i++) begin
            dac_sel = 2'(i);
            tick(3);
            chk("dac code", dac_code_ff, res_tbl[i][14:4]);
        end
        chk("alarm two oe", second_io_pin_oe_ff, 1'b1);
        chk("alarm two idle", second_io_pin_out_ff, 1'b0);
        {alarm_one_en, a1_dir_high, a1_thr_lo} = {2'h3, 15'h0100};
        {a1_thr_hi, a1_hyst, bridge_result} = {15'h0300, 15'h0010, 15'h0200};
        tick(6);
        chk("alarm on", output_driver_b_ff, 1'b1);
        bridge_result = 15'h0080;
        tick(6);
        chk("alarm off", output_driver_b_ff, 1'b0);
        {a1_window, bridge_result} = {1'b1, 15'h0200};
        tick(6);
        chk("window inside", output_driver_b_ff, 1'b1);
        bridge_result = 15'h0400;
        tick(6);
        chk("window outside", output_driver_b_ff, 1'b0);
        {a1_window, a1_on_dly, bridge_result} = {1'b0, 16'h0010, 15'h0200};
        a2_thr_lo = 15'h7000;
        tick(10);
        chk("on delay wait", output_driver_b_ff, 1'b0);
        tick(12);
        chk("on delay done", output_driver_b_ff, 1'b1);
        chk("alarm two low", second_io_pin_out_ff, 1'b1);
    endtask
    task automatic t_pwm();
        int hi [2];
        {dac_en, pulse_one_en, pulse_two_en} = 3'h3;
        {pulse_one_sel, pulse_two_sel} = 4'h1;
        {bridge_result, temp1_result} = {15'h4000, 15'h2000};
        for (int r = 0; r < 2; r++) begin
            pwm_res = (r != 0) ? 4'hF : 4'h9;
            tick(4);
            hi = '{0, 0};
            repeat ((r != 0) ? 8192 : 1024) begin
                tick(1);
                hi[0] += output_driver_b_ff;
                hi[1] += output_driver_a_ff;
            end
            chk("pulse one duty", 16'(hi[0]), (r != 0) ? 4096 : 512);
            chk("pulse two duty", 16'(hi[1]), (r != 0) ? 2048 : 256);
        end
        chk("pulse one oe", first_io_pin_oe_ff, 1'b1);
        {pulse_one_en, pulse_two_en} = 2'h0;
    endtask
    task automatic t_fault();
        for (int k = 0; k < 6; k++) begin
            {parity_fault, sig_fault, mem_fault, cm_fault, inp_hi_fault,
             inp_lo_fault} = 6'h01 << k;
            err_high_sel = k[0];
            tick(3);
            chk("diag set", diag_mode_ff, 1'b1);
            chk("err code", err_code_ff, code_tbl[k]);
            chk("diag dac", dac_code_ff, {11{err_high_sel}});
            chk("diag pin", output_driver_a_ff, err_high_sel);
            {parity_fault, sig_fault, mem_fault, cm_fault} = 4'h0;
            {inp_hi_fault, inp_lo_fault} = 2'h0;
            tick(2);
            chk("diag held", diag_mode_ff, 1'b1);
            err_clear = 1'b1;
            tick(1);
            err_clear = 1'b0;
            tick(2);
            chk("diag cleared", diag_mode_ff, 1'b0);
        end
        loop_tick = 1'b0;
        tick(30);
        chk("watchdog code", err_code_ff, 8'h01);
        loop_tick = 1'b1;
    endtask
    initial begin
        {rst, dac_en, pulse_one_en, pulse_two_en, alarm_one_en, alarm_two_en,
         a1_dir_high, a1_window, a2_dir_high, a2_window, inp_lo_fault,
         inp_hi_fault, cm_fault, mem_fault, sig_fault, parity_fault,
         err_clear, err_high_sel, cfg_spi, cfg_start_win_en} = '0;
        {bridge_result, temp1_result, temp2_result, a1_thr_lo} = '0;
        {a1_thr_hi, a1_hyst, a2_thr_lo, a2_thr_hi, a2_hyst} = '0;
        {a1_on_dly, a1_off_dly, a2_on_dly, a2_off_dly} = '0;
        {dac_sel, pulse_one_sel, pulse_two_sel, pwm_res} = {6'h00, 4'h9};
        {pwm_div, proc_alive, loop_tick} = {8'h01, 2'h3};
        t_window();
        t_cmd();
        t_nowin();
        t_route();
        t_pwm();
        t_fault();
        give_verdict();
    end
    initial begin
        #2000000;
        num_errors++;
        give_verdict();
    end
endmodule // tb_top
bind soc_output_stage soc_os_properties i_soc_os_properties (.ref_clk, .rst,
    .inp_lo_fault, .inp_hi_fault, .cm_fault, .mem_fault, .sig_fault,
    .parity_fault, .err_clear, .err_high_sel, .cmd_exit, .if_mode_ff,
    .diag_mode_ff, .err_code_ff, .dac_code_ff, .output_driver_a_ff,
    .second_io_pin_oe_ff);
`default_nettype wire
